// >>> ssr_pkg.sv
// Constants, types and helper functions of the serial absolute encoder reader.
// Assumes a 10 MHz APB clock; the encoder sits on a clock/data serial link.
// What this block does
// R1: A read command clocks the encoder, captures the word, stores the result.
// R2: Position word length is configurable from 8 to 29 data bits.
// R3: Up to two trailing control bits are stripped and shown as two flags.
// R4: Rate code 0..3 selects 100, 200, 300 or 500 kHz serial clock.
// R5: Code bit 0 converts Gray to binary, 1 passes binary through.
// R6: Gray conversion covers the trailing control bits too.
// R7: Ring mode reads the same position twice and compares both values.
// R8: In ring mode matching values are valid and get stored.
// R9: After 3 failed double reads set ring error flag and diagnostic code.
// R10: A zero command first captures the position with no offset applied.
// R11: The zero command stores that raw capture into the offset register.
// R12: Later reads subtract the offset, giving signed results around zero.
// R13: Writing zero to the offset register gives raw absolute positions.
// R14: Identification returns 12 bits: module part and version; unread gives 0.
// R15: Serial clock idles high, data sampled on edges, pause after each word; in ring mode only after the second word.
package ssr_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0c;
  localparam logic [7:0] ADDR_OFFSET = 8'h10;
  localparam logic [7:0] ADDR_IDENT = 8'h14;
  localparam logic [7:0] ADDR_DIAG = 8'h18;
  localparam logic [7:0] ADDR_ISTAT = 8'h1c;
  localparam logic [7:0] ADDR_IMASK = 8'h20;

  // Command bit positions.
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_ZERO_BIT = 1;
  localparam int CMD_IDENT_BIT = 2;

  // Status bit positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CB1_BIT = 1;
  localparam int ST_CB2_BIT = 2;
  localparam int ST_RING_BIT = 3;

  // Interrupt status and mask bit positions.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_RING_BIT = 1;

  // Word length limits and ring retry count.
  localparam logic [4:0] NBITS_MIN = 5'd8;
  localparam logic [4:0] NBITS_MAX = 5'd29;
  localparam logic [1:0] CBITS_MAX = 2'd2;
  localparam logic [1:0] RING_TRIES = 2'd3;
  localparam logic [7:0] DIAG_RING_CODE = 8'h01;

  // Identification parts; both values are arbitrary.
  localparam logic [7:0] ID_MODULE = 8'h5a;
  localparam logic [3:0] ID_VERSION = 4'h1;

  // Timing in ns and the derived counts of pclk cycles.
  localparam int CLK_NS = 100;
  localparam int HALF0_NS = 5000;
  localparam int HALF1_NS = 2500;
  localparam int HALF2_NS = 1666;
  localparam int HALF3_NS = 1000;
  localparam int PAUSE_NS = 30000;
  localparam logic [8:0] HALF0_CYC = 9'(HALF0_NS / CLK_NS);
  localparam logic [8:0] HALF1_CYC = 9'(HALF1_NS / CLK_NS);
  localparam logic [8:0] HALF2_CYC = 9'(HALF2_NS / CLK_NS);
  localparam logic [8:0] HALF3_CYC = 9'(HALF3_NS / CLK_NS);
  localparam logic [8:0] PAUSE_CYC = 9'((PAUSE_NS + CLK_NS - 1) / CLK_NS);

  // Configuration register layout.
  typedef struct packed {
    logic ring;
    logic bin;
    logic [1:0] rate;
    logic [1:0] cbits;
    logic [4:0] nbits;
  } ssr_cfg_t;

  localparam ssr_cfg_t CFG_RST = 11'h018;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_PAUSE} ssr_state_t;
  typedef enum logic {OP_READ, OP_ZERO} ssr_op_t;

  // Half period of the serial clock for a rate code.
  function automatic logic [8:0] half_cycles(input logic [1:0] rate);
    case (rate)
      2'd0: return HALF0_CYC;
      2'd1: return HALF1_CYC;
      2'd2: return HALF2_CYC;
      default: return HALF3_CYC;
    endcase
  endfunction : half_cycles

  // Gray to binary over the whole right-aligned word.
  function automatic logic [31:0] gray2bin(input logic [31:0] g);
    logic [31:0] b;
    b = g;
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

endpackage : ssr_pkg

// >>> ssr_sync.sv
// Two-stage synchroniser for one input coming from outside the pclk domain.
// Assumes the input changes slowly compared with pclk.
`timescale 1ns/1ps
module ssr_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;

  // Only the second stage is visible; the first may be metastable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : ssr_sync

// >>> ssr_reader.sv
// Serial absolute encoder reader: APB slave, serial clock master and result logic.
// Assumes the encoder shifts a bit out after each rising serial clock edge.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module ssr_reader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ssi_clk,
  input wire logic ssi_data,
  output logic irq,
  output logic ring_compare_error_flag,
  output logic control_bit_one_flag,
  output logic control_bit_two_flag
);
  import ssr_pkg::*;

  logic data_s;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  ssr_cfg_t cfg_q, cfg_d;
  logic [1:0] mask_q, mask_d, istat_q, istat_d;
  logic [11:0] ident_q, ident_d;
  ssr_state_t state_q, state_d;
  ssr_op_t op_q, op_d;
  logic [8:0] cnt_q, cnt_d;
  logic [5:0] bits_q, bits_d;
  logic [63:0] shift_q, shift_d;
  logic [1:0] tries_q, tries_d;
  logic sclk_q, sclk_d, cb1_q, cb1_d, cb2_q, cb2_d, rerr_q, rerr_d;
  logic [31:0] pos_q, pos_d, offset_q, offset_d;
  logic [7:0] diag_q, diag_d;
  logic acc, done, wr_done, rd_done, hit, cmd_wr;
  logic go_read, go_zero, ev_done, ev_ring, match, finish;
  logic [5:0] flen, total;
  logic [8:0] half_cyc;
  logic [31:0] mask32, word_a, word_b, conv, pos_raw, rd_val;

  // The data pin is asynchronous to pclk.
  ssr_sync u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(ssi_data),
    .dout(data_s)
  );

  // Frame geometry and captured word decoding.
  always_comb begin
    flen = 6'(cfg_q.nbits) + 6'(cfg_q.cbits);
    total = cfg_q.ring ? 6'(flen << 1) : flen;
    half_cyc = half_cycles(cfg_q.rate); // see R4
    mask32 = (32'h1 << flen) - 32'h1;
    word_b = shift_q[31:0] & mask32;
    word_a = 32'(shift_q >> flen) & mask32;
    match = (word_a == word_b); // see R7
    conv = cfg_q.bin ? word_b : gray2bin(word_b); // see R5, see R6
    pos_raw = conv >> cfg_q.cbits; // see R3
  end

  // APB decode; every access takes one wait state so read data is registered.
  always_comb begin
    acc = psel && penable;
    done = acc && pready_q;
    wr_done = done && pwrite;
    rd_done = done && !pwrite;
    cmd_wr = wr_done && (paddr == ADDR_CMD);
    go_read = cmd_wr && pwdata[CMD_READ_BIT] && (state_q == ST_IDLE);
    go_zero = cmd_wr && pwdata[CMD_ZERO_BIT] && !pwdata[CMD_READ_BIT] && (state_q == ST_IDLE);
    hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      ADDR_CTRL: rd_val = 32'(cfg_q);
      ADDR_CMD: rd_val = 32'h0;
      ADDR_STATUS: begin
        rd_val[ST_BUSY_BIT] = (state_q != ST_IDLE);
        rd_val[ST_CB1_BIT] = cb1_q;
        rd_val[ST_CB2_BIT] = cb2_q;
        rd_val[ST_RING_BIT] = rerr_q;
      end
      ADDR_POS: rd_val = pos_q;
      ADDR_OFFSET: rd_val = offset_q;
      ADDR_IDENT: rd_val = 32'(ident_q);
      ADDR_DIAG: rd_val = 32'(diag_q);
      ADDR_ISTAT: rd_val = 32'(istat_q);
      ADDR_IMASK: rd_val = 32'(mask_q);
      default: hit = 1'b0;
    endcase
  end

  // Bus side registers: configuration, mask, sticky events, identification.
  always_comb begin
    pready_d = acc && !pready_q;
    prdata_d = (acc && !pready_q && !pwrite) ? rd_val : 32'h0;
    pslverr_d = acc && !pready_q && !hit;
    cfg_d = cfg_q;
    mask_d = mask_q;
    ident_d = ident_q;
    // Configuration writes while busy would change the frame mid-flight, so they are dropped.
    if (wr_done && paddr == ADDR_CTRL && state_q == ST_IDLE) begin
      cfg_d = ssr_cfg_t'(pwdata[10:0]);
      if (cfg_d.nbits < NBITS_MIN) begin
        cfg_d.nbits = NBITS_MIN; // see R2
      end else if (cfg_d.nbits > NBITS_MAX) begin
        cfg_d.nbits = NBITS_MAX; // see R2
      end
      if (cfg_d.cbits > CBITS_MAX) begin
        cfg_d.cbits = CBITS_MAX; // see R3
      end
    end
    if (wr_done && paddr == ADDR_IMASK) begin
      mask_d = pwdata[1:0];
    end
    if (cmd_wr && pwdata[CMD_IDENT_BIT]) begin
      ident_d = {ID_MODULE, ID_VERSION}; // see R14
    end
    // Only the bits that the answering read reported are cleared. An event that lands while the read is in
    // flight stays pending, and an event in the clearing cycle itself is set again below.
    istat_d = (rd_done && paddr == ADDR_ISTAT) ? (istat_q & ~prdata_q[1:0]) : istat_q;
    istat_d[IRQ_DONE_BIT] = istat_d[IRQ_DONE_BIT] | ev_done;
    istat_d[IRQ_RING_BIT] = istat_d[IRQ_RING_BIT] | ev_ring;
    irq_d = |(istat_d & mask_d);
  end

  // Bus side register stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
      cfg_q <= CFG_RST;
      mask_q <= 2'b00;
      istat_q <= 2'b00;
      ident_q <= 12'h000;
      irq_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      istat_q <= istat_d;
      ident_q <= ident_d;
      irq_q <= irq_d;
    end
  end

  // Serial engine: low half, high half with sample at its end, then recovery pause.
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    shift_d = shift_q;
    tries_d = tries_q;
    sclk_d = sclk_q;
    cb1_d = cb1_q;
    cb2_d = cb2_q;
    rerr_d = rerr_q;
    pos_d = pos_q;
    offset_d = offset_q;
    diag_d = diag_q;
    ev_done = 1'b0;
    ev_ring = 1'b0;
    finish = 1'b0;
    if (wr_done && paddr == ADDR_OFFSET) begin
      offset_d = pwdata; // see R13
    end
    case (state_q)
      ST_IDLE: begin
        if (go_read || go_zero) begin
          op_d = go_zero ? OP_ZERO : OP_READ;
          tries_d = 2'd0;
          state_d = ST_LOW;
          sclk_d = 1'b0; // see R1
          cnt_d = half_cyc;
          bits_d = 6'd0;
          shift_d = 64'h0;
        end
      end
      ST_LOW: begin
        if (cnt_q == 9'd1) begin
          state_d = ST_HIGH;
          sclk_d = 1'b1;
          cnt_d = half_cyc;
        end else begin
          cnt_d = cnt_q - 9'd1;
        end
      end
      ST_HIGH: begin
        if (cnt_q == 9'd1) begin
          shift_d = {shift_q[62:0], data_s}; // see R15
          bits_d = bits_q + 6'd1;
          if (bits_q + 6'd1 == total) begin
            state_d = ST_PAUSE; // see R15
            cnt_d = PAUSE_CYC;
          end else begin
            state_d = ST_LOW;
            sclk_d = 1'b0;
            cnt_d = half_cyc;
          end
        end else begin
          cnt_d = cnt_q - 9'd1;
        end
      end
      ST_PAUSE: begin
        if (cnt_q != 9'd1) begin
          cnt_d = cnt_q - 9'd1;
        end else if (cfg_q.ring && !match && tries_q != RING_TRIES - 2'd1) begin
          tries_d = tries_q + 2'd1; // see R9
          state_d = ST_LOW;
          sclk_d = 1'b0;
          cnt_d = half_cyc;
          bits_d = 6'd0;
          shift_d = 64'h0;
        end else if (cfg_q.ring && !match) begin
          state_d = ST_IDLE;
          rerr_d = 1'b1; // see R9
          diag_d = DIAG_RING_CODE;
          ev_ring = 1'b1;
          ev_done = 1'b1;
        end else begin
          state_d = ST_IDLE; // see R8
          finish = 1'b1;
          ev_done = 1'b1;
          rerr_d = 1'b0;
          cb1_d = (cfg_q.cbits == 2'd2) ? conv[1] : ((cfg_q.cbits == 2'd1) && conv[0]); // see R3
          cb2_d = (cfg_q.cbits == 2'd2) && conv[0];
          if (op_q == OP_ZERO) begin
            offset_d = pos_raw; // see R10, see R11
          end else begin
            pos_d = pos_raw - offset_q; // see R12
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        sclk_d = 1'b1;
      end
    endcase
  end

  // Serial engine register stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      op_q <= OP_READ;
      cnt_q <= 9'd0;
      bits_q <= 6'd0;
      shift_q <= 64'h0;
      tries_q <= 2'd0;
      sclk_q <= 1'b1;
      cb1_q <= 1'b0;
      cb2_q <= 1'b0;
      rerr_q <= 1'b0;
      pos_q <= 32'h0;
      offset_q <= 32'h0;
      diag_q <= 8'h00;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      tries_q <= tries_d;
      sclk_q <= sclk_d;
      cb1_q <= cb1_d;
      cb2_q <= cb2_d;
      rerr_q <= rerr_d;
      pos_q <= pos_d;
      offset_q <= offset_d;
      diag_q <= diag_d;
    end
  end

  // All outputs come straight from registers.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ssi_clk = sclk_q;
  assign irq = irq_q;
  assign ring_compare_error_flag = rerr_q;
  assign control_bit_one_flag = cb1_q;
  assign control_bit_two_flag = cb2_q;

  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence pause_entry_s;
    state_q == ST_HIGH && cnt_q == 9'd1 && bits_q + 6'd1 == total;
  endsequence
  sequence pause_full_s;
    ##299 state_q == ST_PAUSE && cnt_q == 9'd1;
  endsequence

  idle_clock_high_a: assert property (state_q == ST_IDLE |-> sclk_q) // see R15
    else $error("serial clock not high while idle");
  start_clock_low_a: assert property (go_read |=> state_q == ST_LOW && !sclk_q) // see R1
    else $error("read command did not start the serial clock");
  half_period_a: assert property ($rose(state_q == ST_HIGH) |-> cnt_q == $past(half_cyc)) // see R4
    else $error("serial clock half period does not match rate");
  pause_length_a: assert property (pause_entry_s |=> sclk_q ##0 pause_full_s) // see R15
    else $error("recovery pause has wrong length");
  zero_store_a: assert property (finish && op_q == OP_ZERO |=> offset_q == $past(pos_raw)) // see R11
    else $error("zero command did not store raw position");
  offset_sub_a: assert property (finish && op_q == OP_READ |=> pos_q == $past(pos_raw) - $past(offset_q)) // see R12
    else $error("position not offset corrected");
  ring_fail_a: assert property (ev_ring |-> tries_q == 2'd2 ##1 rerr_q && diag_q == DIAG_RING_CODE) // see R9
    else $error("ring error raised at wrong try or without code");
  ring_retry_a: assert property (state_q == ST_PAUSE && cnt_q == 9'd1 && cfg_q.ring && !match // see R7
    && tries_q < 2'd2 |=> state_q == ST_LOW && tries_q == $past(tries_q) + 2'd1)
    else $error("ring mismatch did not retry");
  ctrl_bits_a: assert property (finish && cfg_q.cbits == 2'd2 |=> // see R3
    cb1_q == $past(conv[1]) && cb2_q == $past(conv[0]))
    else $error("control bits not separated");
  ident_value_a: assert property (cmd_wr && pwdata[CMD_IDENT_BIT] |=> ident_q == {ID_MODULE, ID_VERSION}) // see R14
    else $error("identification value not loaded");
  irq_level_a: assert property (irq_q == |(istat_q & mask_q))
    else $error("interrupt output disagrees with masked status");

endmodule : ssr_reader

// >>> ssr_enc_model.sv
// Behavioural absolute encoder on the serial link, the far side of the reader.
// Assumes the bench sets word, len and bad through hierarchy before each frame.
`timescale 1ns/1ps
module ssr_enc_model (
  input wire logic sclk,
  output logic sdata
);
  logic [31:0] word;
  int len;
  logic bad;
  logic armed;
  int cnt;
  time t_rise;

  // The line idles high, as a released pulled-up data line does.
  initial begin
    word = 32'h0;
    len = 8;
    bad = 1'b0;
    armed = 1'b0;
    cnt = 0;
    t_rise = 0;
    sdata = 1'b1;
  end

  // Shifts the next bit, MSB first, after each rising clock edge; past one word the
  // word repeats, which the double read relies on; bad spoils only the second copy.
  always @(posedge sclk) begin
    if (armed) begin
      sdata <= word[len - 1 - (cnt % len)] ^ (bad && cnt >= len && cnt < 2 * len);
      cnt++;
      t_rise = $time;
    end
  end

  // The step of the clock line into its reset level is no clock edge, so shifting waits for a first fall.
  always @(negedge sclk) armed = 1'b1;

  // Recovery timer: clock high for 15 us ends the frame and releases the line.
  always begin
    #1000;
    if (cnt != 0 && ($time - t_rise) > 15000) begin
      cnt = 0;
      sdata = 1'b1;
    end
  end
endmodule : ssr_enc_model

// >>> ssr_reader_tb_top.sv
// Self-checking bench of the serial encoder reader, driven over APB.
// Assumes the encoder model of its own file sits on the serial link.
`timescale 1ns/1ps
module ssr_reader_tb_top;
  import ssr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ssi_clk, ssi_data, irq;
  logic ring_f, cb1_f, cb2_f, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, cmp_count, falls, lowcnt, lowlen;
  int half [4] = '{HALF0_CYC, HALF1_CYC, HALF2_CYC, HALF3_CYC};

  ssr_reader i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ssi_clk(ssi_clk), .ssi_data(ssi_data), .irq(irq), .ring_compare_error_flag(ring_f),
    .control_bit_one_flag(cb1_f), .control_bit_two_flag(cb2_f));
  ssr_enc_model i_enc (.sclk(ssi_clk), .sdata(ssi_data));

  // The 10 MHz bus clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Counts serial clock falling edges and keeps the length of the last low half.
  always @(negedge ssi_clk) falls++;
  always @(posedge pclk) begin
    if (ssi_clk === 1'b0) lowcnt++;
    else if (lowcnt != 0) begin
      lowlen = lowcnt;
      lowcnt = 0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the idle cycle at the end keeps two calls off the same edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Issues a command and polls busy under a bounded count; the frame count restarts.
  task automatic run(input logic [31:0] cmd);
    int k;
    k = 0;
    falls = 0;
    apb(1'b1, ADDR_CMD, cmd);
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      fail_count++;
      results();
    end
  endtask : run

  task automatic cfg(input logic ring, input logic bin, input logic [1:0] rate, input logic [1:0] cb,
                     input logic [4:0] nb);
    apb(1'b1, ADDR_CTRL, 32'(ssr_cfg_t'{ring, bin, rate, cb, nb}));
    i_enc.len = int'(nb) + int'(cb);
  endtask : cfg

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // A hang past 5 ms, well over the expected run, ends the test as a failure.
  initial begin
    #5000000;
    fail_count++;
    results();
  end

  // Main sequence: reset, identification, rates, control bits, Gray, zeroing, ring mode.
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(ssi_clk, 1'b1);
    rdc(ADDR_CTRL, 32'h18);
    rdc(ADDR_IDENT, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk(err, 1'b1);
    run(32'h1 << CMD_IDENT_BIT);
    rdc(ADDR_IDENT, {ID_MODULE, ID_VERSION});
    // Every rate code, checked by the low half length and the bit count.
    for (int r = 0; r < 4; r++) begin
      cfg(1'b0, 1'b1, 2'(r), 2'd0, 5'd8);
      i_enc.word = 32'h5a + r;
      run(32'h1 << CMD_READ_BIT);
      chk(lowlen, half[r]);
      chk(falls, 8);
      rdc(ADDR_POS, 32'h5a + r);
    end
    // The done event stays pending while masked, then an interrupt status read clears it.
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    rdc(ADDR_ISTAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    // Two trailing control bits, binary word.
    cfg(1'b0, 1'b1, 2'd3, 2'd2, 5'd12);
    i_enc.word = {12'habc, 2'b10};
    run(32'h1);
    rdc(ADDR_POS, 32'habc);
    chk({cb1_f, cb2_f}, 2'b10);
    chk(rd >> 12, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h6, 32'h2);
    // Gray word whose raw last bit is 0 but whose converted control bit is 1.
    cfg(1'b0, 1'b0, 2'd3, 2'd1, 5'd10);
    i_enc.word = 32'h58b ^ 32'h2c5;
    run(32'h1);
    rdc(ADDR_POS, 32'h2c5);
    chk(cb1_f, 1'b1);
    // Zeroing ignores the old offset, then later reads go relative and signed.
    cfg(1'b0, 1'b1, 2'd3, 2'd0, 5'd16);
    apb(1'b1, ADDR_OFFSET, 32'h7);
    i_enc.word = 32'h1234;
    run(32'h1 << CMD_ZERO_BIT);
    rdc(ADDR_OFFSET, 32'h1234);
    run(32'h1);
    rdc(ADDR_POS, 32'h0);
    i_enc.word = 32'h1230;
    run(32'h1);
    rdc(ADDR_POS, 32'hfffffffc);
    apb(1'b1, ADDR_OFFSET, 32'h0);
    run(32'h1);
    rdc(ADDR_POS, 32'h1230);
    // Ring mode: a clean double read, then three spoilt ones.
    cfg(1'b1, 1'b1, 2'd3, 2'd0, 5'd10);
    i_enc.word = 32'h2a5;
    run(32'h1);
    chk(falls, 20);
    rdc(ADDR_POS, 32'h2a5);
    chk(ring_f, 1'b0);
    apb(1'b0, ADDR_ISTAT, 32'h0);
    apb(1'b1, ADDR_IMASK, 32'h3);
    i_enc.bad = 1'b1;
    i_enc.word = 32'h111;
    run(32'h1);
    chk(falls, 60);
    chk(ring_f, 1'b1);
    chk(irq, 1'b1);
    rdc(ADDR_DIAG, DIAG_RING_CODE);
    rdc(ADDR_POS, 32'h2a5);
    rdc(ADDR_ISTAT, 32'h3);
    results();
  end
endmodule : ssr_reader_tb_top
